//--- hw/smw_pkg.sv
// Package for the scratchpad write-access block: commands, field positions,
// reset values and copy timing shared by both ends.
// Assumes a 100 MHz core clock on both ends.
package smw_pkg;
  // Command codes on the byte link
  localparam logic [7:0] CMD_WRITE_PAD = 8'h0f;
  localparam logic [7:0] CMD_READ_PAD = 8'haa;
  localparam logic [7:0] CMD_COPY_PAD = 8'h99;
  // Scratchpad geometry
  localparam int PAD_BYTES = 32;
  localparam logic [4:0] PAD_LAST = 5'h1f;
  // Status byte field positions
  localparam int ST_AA_BIT = 7;
  localparam int ST_ZERO_BIT = 6;
  localparam int ST_PF_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY_REV = 16'ha001;
  // Byte returned after the copy completes, and the idle fill value
  localparam logic [7:0] COPY_DONE_PATTERN = 8'haa;
  localparam logic [7:0] IDLE_FILL = 8'hff;
  // Copy timing: 2 us per byte at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int COPY_BYTE_NS = 2000;
  localparam int COPY_BYTE_CYC = (COPY_BYTE_NS * CLK_MHZ + 999) / 1000;
  // Register pages: page numbers from two above this value upward are write protected while a mission runs
  localparam logic [10:0] REG_PAGE_FIRST = 11'h010;
  localparam int PASSWORD_BYTES = 8;
  // APB register offsets of the controller
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_PWLO = 8'h14;
  localparam logic [7:0] OFS_PWHI = 8'h18;

  // CRC-16 one byte step, reflected polynomial, LSB first
  function automatic logic [15:0] smw_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ CRC_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

//--- hw/smw_link_if.sv
// Byte-level link between the bus master controller and the device.
// Assumes both ends share i_core_clk; bit timing is abstracted to bytes.
`timescale 1ns/100ps
`default_nettype none
interface smw_link_if;
  logic bus_reset;      // Bus reset pulse from master
  logic overdrive_flag; // Speed select from master
  logic m_valid;        // Master writes a byte
  logic [7:0] m_data;   // Master byte
  logic [2:0] m_bits;   // Bits in last byte, 0 = full byte
  logic m_last;         // End of write stream marker; master ties it low
  logic m_read;         // Master read request (8 read slots)
  logic s_valid;        // Device answers a read
  logic [7:0] s_data;   // Device byte
  logic s_busy;         // Device busy copying

  modport master (output bus_reset, overdrive_flag, m_valid, m_data, m_bits, m_last, m_read,
                  input s_valid, s_data, s_busy);
  modport device (input bus_reset, overdrive_flag, m_valid, m_data, m_bits, m_last, m_read,
                  output s_valid, s_data, s_busy);
endinterface
`default_nettype wire

//--- hw/smw_crc16.sv
// CRC-16 accumulator used by the device end.
// Assumes clear with shift means a fresh stream that starts with this byte.
`timescale 1ns/100ps
`default_nettype none
module smw_crc16
  import smw_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_shift,
  input wire logic [7:0] i_byte,
  // Result
  output logic [15:0] o_crc
);
  typedef struct packed {
    logic [15:0] crc;
  } smw_crc_state_type;
  smw_crc_state_type st_reg, st_next;

  // Clear has priority so a new command always starts clean
  always_comb begin
    st_next = st_reg;
    if (i_clear) begin
      // The command byte is shifted into the cleared generator in the same cycle
      st_next.crc = i_shift ? smw_crc_byte(CRC_INIT, i_byte) : CRC_INIT;
    end else if (i_shift) begin
      st_next.crc = smw_crc_byte(st_reg.crc, i_byte);
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg <= '{crc: CRC_INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_crc = st_reg.crc;
endmodule
`default_nettype wire

//--- hw/smw_device.sv
// Device end: scratchpad, address registers, CRC and copy into memory.
// Assumes the master sends whole bytes except possibly the last of a write.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R01 - Status low bits hold last written offset
// R02 - Copy only when ending offset is 1Fh
// R03 - Partial byte sets bit 5; bit 6 zero
// R04 - Target low bits give starting offset
// R05 - Status byte is read only
// R06 - Valid copy sets flag; write clears it
// R07 - Write: command, address low/high, data
// R08 - Incomplete final byte dropped, flag set
// R09 - Write CRC covers command, address, data
// R10 - Full write lets master read CRC
// R11 - Mission blocks copies to register pages
// R12 - Read returns address, status, pad data
// R13 - Read ends with inverted CRC, then ones
// R14 - Copy: address echo then password
// R15 - Wrong password aborts until bus reset
// R16 - Good pattern sets flag and copies
// R17 - After copy send alternating pattern
// R18 - Bus reset ignored during copy
// R19 - Data and calibration pages always copy
// R20 - Standard speed unless overdrive selected
// R21 - Mission memory activity takes priority
// R22 - Scratchpad holds 32 bytes
// R23 - CRC uses 8005 polynomial, LSB first
module smw_device
  import smw_pkg::*;
#(
  parameter int MEM_BYTES = 4096
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Link
  smw_link_if.device link,
  // Device environment
  input wire logic i_mission_running,
  input wire logic i_internal_busy,
  input wire logic i_password_enable,
  input wire logic [63:0] i_full_password,
  // Memory write port
  output logic o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  // Observation
  output logic [7:0] o_status,
  output logic o_overdrive
);
  typedef enum {S_CMD, S_TA1, S_TA2, S_WDATA, S_RHDR, S_RDATA, S_RCRC, S_WCRC,
                S_CAUTH, S_CPW, S_COPY, S_DONE, S_ONES, S_DEAD} smw_dev_fsm_type;

  typedef struct packed {
    smw_dev_fsm_type fsm;
    logic [7:0] ta_lo;
    logic [7:0] ta_hi;
    logic [4:0] end_ofs;
    logic pf;
    logic aa;
    logic [4:0] ptr;
    logic [1:0] idx;
    logic [2:0] pw_idx;
    logic auth_ok;
    logic pw_ok;
    logic [15:0] wait_cnt;
    logic s_valid;
    logic [7:0] s_data;
    logic [7:0] cmd;
    logic [15:0] crc_hold;
    logic od;
    logic we;
    logic [15:0] waddr;
    logic [7:0] wdata;
  } smw_dev_state_type;

  smw_dev_state_type st_reg, st_next;
  logic [7:0] pad_reg [PAD_BYTES];   // Scratchpad storage
  logic pad_we;
  logic [4:0] pad_waddr;
  logic crc_clear, crc_shift;
  logic [7:0] crc_byte;
  logic [15:0] crc_val;
  logic [7:0] status_byte;
  logic protect_hit;

  // CRC engine for the write stream; the read stream CRC is kept in crc_hold
  smw_crc16 u_crc (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(crc_clear),
    .i_shift(crc_shift),
    .i_byte(crc_byte),
    .o_crc(crc_val)
  );

  // Status byte view: bit 6 is hard zero
  assign status_byte = {st_reg.aa, 1'b0, st_reg.pf, st_reg.end_ofs}; // R01 R03 R05

  // Register pages are the ones above the 16 data and 2 calibration pages
  assign protect_hit = i_mission_running &&
                       ({st_reg.ta_hi, st_reg.ta_lo[7:5]} >= (REG_PAGE_FIRST + 11'h002)); // R11 R19

  // Next state logic
  always_comb begin
    st_next = st_reg;
    st_next.s_valid = 1'b0;
    st_next.we = 1'b0;
    pad_we = 1'b0;
    pad_waddr = st_reg.ptr;
    crc_clear = 1'b0;
    crc_shift = 1'b0;
    crc_byte = link.m_data;
    st_next.od = link.overdrive_flag; // R20
    if (link.bus_reset && st_reg.fsm != S_COPY) begin
      st_next.fsm = S_CMD; // R18
    end else begin
      unique case (st_reg.fsm)
        S_CMD: begin
          if (link.m_valid && !i_internal_busy) begin // R21
            st_next.cmd = link.m_data;
            crc_clear = 1'b1;
            crc_shift = 1'b1; // R09
            st_next.idx = 2'd0;
            unique case (link.m_data)
              CMD_WRITE_PAD: begin
                st_next.fsm = S_TA1;
                st_next.crc_hold = smw_crc_byte(CRC_INIT, link.m_data); // R09
              end
              CMD_READ_PAD: begin
                st_next.fsm = S_RHDR;
                st_next.crc_hold = smw_crc_byte(CRC_INIT, link.m_data);
              end
              CMD_COPY_PAD: begin
                st_next.fsm = S_CAUTH;
                st_next.auth_ok = 1'b1;
                st_next.pw_ok = 1'b1;
                st_next.pw_idx = 3'd0;
              end
              default: st_next.fsm = S_DEAD;
            endcase
          end
        end
        S_TA1: begin
          if (link.m_valid) begin // R07
            st_next.ta_lo = link.m_data;
            crc_shift = 1'b1;
            st_next.crc_hold = smw_crc_byte(st_reg.crc_hold, link.m_data);
            st_next.fsm = S_TA2;
          end
        end
        S_TA2: begin
          if (link.m_valid) begin
            st_next.ta_hi = link.m_data;
            crc_shift = 1'b1;
            st_next.crc_hold = smw_crc_byte(st_reg.crc_hold, link.m_data);
            st_next.ptr = st_reg.ta_lo[4:0]; // R04
            st_next.end_ofs = st_reg.ta_lo[4:0];
            st_next.pf = 1'b0;
            st_next.aa = 1'b0; // R06
            st_next.fsm = S_WDATA;
          end
        end
        S_WDATA: begin
          if (link.m_valid) begin
            if (link.m_bits != 3'd0) begin
              st_next.pf = 1'b1; // R03 R08
              st_next.fsm = S_DEAD;
            end else begin
              pad_we = 1'b1;
              crc_shift = 1'b1; // Discarded partial bytes never reach the engine
              st_next.end_ofs = st_reg.ptr; // R01
              st_next.crc_hold = smw_crc_byte(st_reg.crc_hold, link.m_data); // R09 R23
              if (st_reg.ptr == PAD_LAST) begin
                st_next.fsm = S_WCRC; // R22
                st_next.idx = 2'd0;
              end else begin
                st_next.ptr = st_reg.ptr + 5'd1;
              end
            end
          end
        end
        S_WCRC: begin
          if (link.m_read) begin // R10
            st_next.s_valid = 1'b1;
            st_next.idx = st_reg.idx + 2'd1;
            st_next.s_data = (st_reg.idx == 2'd0) ? ~crc_val[7:0]
                           : (st_reg.idx == 2'd1) ? ~crc_val[15:8] : IDLE_FILL;
          end
        end
        S_RHDR: begin
          if (link.m_read) begin // R12
            st_next.s_valid = 1'b1;
            st_next.s_data = (st_reg.idx == 2'd0) ? st_reg.ta_lo
                           : (st_reg.idx == 2'd1) ? st_reg.ta_hi : status_byte;
            st_next.crc_hold = smw_crc_byte(st_reg.crc_hold, st_next.s_data);
            st_next.idx = st_reg.idx + 2'd1;
            if (st_reg.idx == 2'd2) begin
              st_next.fsm = S_RDATA;
              st_next.ptr = st_reg.ta_lo[4:0];
            end
          end
        end
        S_RDATA: begin
          if (link.m_read) begin
            st_next.s_valid = 1'b1;
            st_next.s_data = pad_reg[st_reg.ptr];
            st_next.crc_hold = smw_crc_byte(st_reg.crc_hold, pad_reg[st_reg.ptr]);
            st_next.ptr = st_reg.ptr + 5'd1;
            if (st_reg.ptr == PAD_LAST) begin
              st_next.fsm = S_RCRC;
              st_next.idx = 2'd0;
            end
          end
        end
        S_RCRC, S_ONES: begin
          if (link.m_read) begin // R13
            st_next.s_valid = 1'b1;
            st_next.idx = st_reg.idx + 2'd1;
            st_next.s_data = (st_reg.fsm == S_ONES) ? IDLE_FILL
                           : (st_reg.idx == 2'd0) ? ~st_reg.crc_hold[7:0] : ~st_reg.crc_hold[15:8];
            if (st_reg.fsm == S_RCRC && st_reg.idx == 2'd1) begin
              st_next.fsm = S_ONES;
            end
          end
        end
        S_CAUTH: begin
          if (link.m_valid) begin // R14
            if ((st_reg.idx == 2'd0 && link.m_data != st_reg.ta_lo) ||
                (st_reg.idx == 2'd1 && link.m_data != st_reg.ta_hi) ||
                (st_reg.idx == 2'd2 && link.m_data != status_byte)) begin
              st_next.auth_ok = 1'b0;
            end
            st_next.idx = st_reg.idx + 2'd1;
            if (st_reg.idx == 2'd2) begin
              st_next.fsm = S_CPW;
            end
          end
        end
        S_CPW: begin
          if (link.m_valid) begin
            if (link.m_data != i_full_password[8*st_reg.pw_idx +: 8]) begin
              st_next.pw_ok = 1'b0;
            end
            st_next.pw_idx = st_reg.pw_idx + 3'd1;
            if (st_reg.pw_idx == 3'(PASSWORD_BYTES - 1)) begin
              st_next.ptr = st_reg.ta_lo[4:0];
              st_next.waddr = {st_reg.ta_hi, st_reg.ta_lo};
              st_next.wait_cnt = 16'd0;
              if (i_password_enable && !(st_next.pw_ok)) begin
                st_next.fsm = S_DEAD; // R15
              end else if (st_reg.auth_ok && st_reg.end_ofs == PAD_LAST && !protect_hit) begin
                st_next.aa = 1'b1; // R02 R16
                st_next.fsm = S_COPY;
              end else begin
                st_next.fsm = S_DEAD; // R11
              end
            end
          end
        end
        S_COPY: begin
          if (!i_internal_busy) begin // R21
            if (st_reg.wait_cnt == 16'(COPY_BYTE_CYC - 1)) begin
              st_next.wait_cnt = 16'd0;
              st_next.we = 1'b1;
              st_next.wdata = pad_reg[st_reg.ptr];
              st_next.waddr = {st_reg.ta_hi, st_reg.ta_lo[7:5], st_reg.ptr}; // R16
              st_next.ptr = st_reg.ptr + 5'd1;
              if (st_reg.ptr == st_reg.end_ofs) begin
                st_next.fsm = S_DONE;
              end
            end else begin
              st_next.wait_cnt = st_reg.wait_cnt + 16'd1;
            end
          end
        end
        S_DONE: begin
          if (link.m_read) begin // R17
            st_next.s_valid = 1'b1;
            st_next.s_data = COPY_DONE_PATTERN;
          end
        end
        S_DEAD: begin
          if (link.m_read) begin
            st_next.s_valid = 1'b1;
            st_next.s_data = IDLE_FILL;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
      st_reg.fsm <= S_CMD;
      st_reg.ta_lo <= RST_ADDR;
      st_reg.ta_hi <= RST_ADDR;
    end else begin
      st_reg <= st_next;
    end
  end

  // Scratchpad storage has no reset; contents are undefined until written
  always_ff @(posedge i_core_clk) begin
    if (pad_we) begin
      pad_reg[pad_waddr] <= link.m_data;
    end
  end

  // Outputs
  assign link.s_valid = st_reg.s_valid;
  assign link.s_data = st_reg.s_data;
  assign link.s_busy = (st_reg.fsm == S_COPY);
  assign o_mem_we = st_reg.we;
  assign o_mem_addr = st_reg.waddr;
  assign o_mem_wdata = st_reg.wdata;
  assign o_status = status_byte;
  assign o_overdrive = st_reg.od;
endmodule
`default_nettype wire

//--- hw/smw_master.sv
// Master end: APB registers drive single byte link operations.
// Assumes software sequences commands; one link op per DATA write or CTRL read slot request.
`timescale 1ns/100ps
`default_nettype none
module smw_master
  import smw_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Link
  smw_link_if.master link
);
  typedef struct packed {
    logic bus_reset;
    logic od;
    logic m_valid;
    logic [7:0] m_data;
    logic [2:0] m_bits;
    logic m_read;
    logic rd_pending;
    logic [7:0] rdata;
    logic rd_done;
    logic [31:0] prdata;
  } smw_mst_state_type;
  smw_mst_state_type st_reg, st_next;
  logic wr_acc, rd_acc;

  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;

  // CTRL: bit0 bus reset pulse, bit1 overdrive, bit2 read slot request, bits 6:4 bit count
  always_comb begin
    st_next = st_reg;
    st_next.bus_reset = 1'b0;
    st_next.m_valid = 1'b0;
    st_next.m_read = 1'b0;
    if (link.s_valid) begin
      st_next.rdata = link.s_data;
      st_next.rd_done = 1'b1;
      st_next.rd_pending = 1'b0;
    end
    if (wr_acc) begin
      unique case (i_paddr)
        OFS_CTRL: begin
          st_next.bus_reset = i_pwdata[0];
          st_next.od = i_pwdata[1];
          st_next.m_bits = i_pwdata[6:4];
          if (i_pwdata[2]) begin
            st_next.m_read = 1'b1;
            st_next.rd_pending = 1'b1;
            st_next.rd_done = 1'b0;
          end
        end
        OFS_DATA: begin
          st_next.m_valid = 1'b1;
          st_next.m_data = i_pwdata[7:0];
        end
        default: ;
      endcase
    end
    st_next.prdata = 32'h0000_0000;
    unique case (i_paddr)
      OFS_CTRL: st_next.prdata = {25'h0, st_reg.m_bits, 2'b00, st_reg.od, 1'b0};
      OFS_STATUS: st_next.prdata = {29'h0, link.s_busy, st_reg.rd_pending, st_reg.rd_done};
      OFS_RDATA: st_next.prdata = {24'h0, st_reg.rdata};
      default: st_next.prdata = 32'h0000_0000;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // APB answers in the access cycle; read data is the combinational view
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata = rd_acc ? st_next.prdata : 32'h0000_0000;
  assign link.bus_reset = st_reg.bus_reset;
  assign link.overdrive_flag = st_reg.od;
  assign link.m_valid = st_reg.m_valid;
  assign link.m_data = st_reg.m_data;
  assign link.m_bits = st_reg.m_bits;
  assign link.m_last = 1'b0;
  assign link.m_read = st_reg.m_read;
endmodule
`default_nettype wire

//--- test/smw_props.sv
// Checker for the byte link between the master and device ends.
// Assumes it sits beside the interface instance and sees its signals directly.
`timescale 1ns/100ps
`default_nettype none
module smw_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Master side of the link
  input wire logic bus_reset,
  input wire logic overdrive_flag,
  input wire logic m_valid,
  input wire logic m_read,
  // Device side of the link
  input wire logic s_valid,
  input wire logic s_busy
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  // A read request is answered on the next cycle unless a copy runs
  AST_READ_ANSWER: assert property (m_read && !s_busy |=> s_valid)
    else $error("read request not answered");
  // The device never answers without a request
  AST_VALID_CAUSE: assert property (s_valid |-> $past(m_read))
    else $error("answer without request");
  // Nothing is sent while the copy is busy
  AST_BUSY_QUIET: assert property (s_busy |-> !s_valid)
    else $error("answer during copy");
  // A copy lasts many cycles, never a short blip
  AST_COPY_MIN: assert property ($rose(s_busy) |-> s_busy [*8])
    else $error("copy ended too soon");
  // Bus reset during a copy does not stop it
  AST_RST_IGNORED: assert property (s_busy && bus_reset |=> s_busy)
    else $error("bus reset broke copy");
  // Master bytes are one-cycle pulses
  AST_BYTE_PULSE: assert property (m_valid |=> !m_valid)
    else $error("byte strobe held");
  // Master never writes and reads in one cycle
  AST_ONE_OP: assert property (!(m_valid && m_read))
    else $error("write and read together");
  // Standard speed after reset
  AST_OD_RESET: assert property ($fell(i_sys_rst) |-> !overdrive_flag)
    else $error("overdrive set after reset");

  // Main scenarios seen
  cover property (m_read ##1 s_valid);
  cover property ($rose(s_busy));
  cover property (s_busy && bus_reset);
endmodule
`default_nettype wire

//--- test/test_scratchpad_memory_write_access.sv
// Testbench: APB drives the master end, which talks to the device end.
// Assumes a 100 MHz clock and the register map of the package.
`timescale 1ns/100ps
`default_nettype none
module test_scratchpad_memory_write_access;
  import smw_pkg::*;
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
  // Clock, reset and APB
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic o_pready, o_pslverr;
  // Device environment and outputs
  logic mission = 1'b0, ibusy = 1'b0, pw_en = 1'b1;
  logic [63:0] full_pw = 64'h0;
  logic o_mem_we, o_overdrive;
  logic [15:0] o_mem_addr;
  logic [7:0] o_mem_wdata, o_status, pad[32], e8;
  // Expectation queues and counters
  logic [7:0] exp_q[$];
  logic [23:0] mem_q[$], m24;
  logic [31:0] rng = 32'd49;
  logic [15:0] crc;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  smw_link_if link();
  smw_master u_smw_master (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .link(link));
  smw_device #(.MEM_BYTES(4096)) u_smw_device (.i_core_clk, .i_sys_rst, .link(link),
    .i_mission_running(mission), .i_internal_busy(ibusy), .i_password_enable(pw_en),
    .i_full_password(full_pw), .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_status, .o_overdrive);
  smw_props u_smw_props (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .bus_reset(link.bus_reset), .overdrive_flag(link.overdrive_flag), .m_valid(link.m_valid),
    .m_read(link.m_read), .s_valid(link.s_valid), .s_busy(link.s_busy));

  // Free-running 100 MHz clock
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Fixed-seed pseudo random source
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Own reflected CRC-16 step, LSB first
  function automatic logic [15:0] cs(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic send(input logic [7:0] b);
    wr(OFS_DATA, {24'h0, b});
  endtask
  // Expect one device byte, request it and wait for it under a bound
  task automatic rd_byte(input logic [7:0] e);
    logic [31:0] q;
    int n;
    exp_q.push_back(e);
    wr(OFS_CTRL, 32'h4);
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b1 && n < 20);
    apb(1'b0, OFS_RDATA, 32'h0, q);
    `CHK("rdata", e, q[7:0])
  endtask
  // Write the pad from the start offset up to last, then an optional partial byte
  task automatic write_pad(input logic [15:0] ta, input logic [4:0] last, input int part);
    wr(OFS_CTRL, 32'h1);
    send(CMD_WRITE_PAD);
    send(ta[7:0]);
    send(ta[15:8]);
    crc = cs(cs(cs(16'h0, CMD_WRITE_PAD), ta[7:0]), ta[15:8]);
    for (int i = ta[4:0]; i <= last; i++) begin
      pad[i] = rng[7:0];
      rng = xs(rng);
      send(pad[i]);
      crc = cs(crc, pad[i]);
    end
    if (part != 0) begin
      wr(OFS_CTRL, 32'(part) << 4);
      send(8'h5a);
      wr(OFS_CTRL, 32'h0);
    end
  endtask
  task automatic read_pad(input logic [15:0] ta, input logic [7:0] es);
    wr(OFS_CTRL, 32'h1);
    send(CMD_READ_PAD);
    crc = cs(cs(cs(cs(16'h0, CMD_READ_PAD), ta[7:0]), ta[15:8]), es);
    rd_byte(ta[7:0]);
    rd_byte(ta[15:8]);
    rd_byte(es);
    for (int i = ta[4:0]; i < 32; i++) begin
      rd_byte(pad[i]);
      crc = cs(crc, pad[i]);
    end
    rd_byte(~crc[7:0]);
    rd_byte(~crc[15:8]);
    rd_byte(IDLE_FILL);
  endtask
  // Copy with address echo and password; the last write lands in the cycle busy drops
  task automatic copy_pad(input logic [15:0] ta, input logic [7:0] es, input logic [63:0] pw);
    wr(OFS_CTRL, 32'h1);
    send(CMD_COPY_PAD);
    send(ta[7:0]);
    send(ta[15:8]);
    send(es);
    for (int i = 0; i < PASSWORD_BYTES; i++) send(pw[8*i +: 8]);
    repeat (20) @(posedge i_core_clk);
    // Bus reset only while copying; a failed copy must stay silent until reset
    if (link.s_busy === 1'b1) wr(OFS_CTRL, 32'h1);
    // Internal activity stalls the copy at random
    do begin
      @(posedge i_core_clk);
      ibusy <= rng[0] & rng[1];
      rng = xs(rng);
    end while (link.s_busy === 1'b1);
    ibusy <= 1'b0;
    repeat (300) @(posedge i_core_clk);
  endtask

  // Result watcher: device bytes and memory writes against the oldest notes
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles > 60000) begin
      miscompares++;
      stop_test();
    end
    if (link.s_valid === 1'b1) begin
      e8 = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK("link byte", e8, link.s_data)
    end
    if (o_mem_we === 1'b1) begin
      m24 = mem_q.size() ? mem_q.pop_front() : 24'hxxxxxx;
      `CHK("mem write", m24, {o_mem_addr, o_mem_wdata})
    end
  end

  initial begin
    logic [31:0] q;
    full_pw = {xs(rng), rng};
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    `CHK("overdrive", 1'b0, o_overdrive)
    apb(1'b0, 8'h40, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wr(OFS_CTRL, 32'h2);
    repeat (2) @(posedge i_core_clk);
    `CHK("overdrive on", 1'b1, o_overdrive)
    wr(OFS_CTRL, 32'h0);
    $display("test speed done");
    // Full page write, CRC read back right after the last byte
    write_pad(16'h0100, 5'h1f, 0);
    rd_byte(~crc[7:0]);
    rd_byte(~crc[15:8]);
    `CHK("status full", 8'h1f, o_status)
    read_pad(16'h0100, 8'h1f);
    $display("test write read done");
    // Good copy to a data page during a mission, bus reset mid-copy
    mission <= 1'b1;
    for (int i = 0; i < 32; i++) mem_q.push_back({16'h0100 + 16'(i), pad[i]});
    copy_pad(16'h0100, 8'h1f, full_pw);
    `CHK("status copied", 8'h9f, o_status)
    rd_byte(COPY_DONE_PATTERN);
    $display("test copy done");
    // Short write ending in a partial byte; copy must not run
    write_pad(16'h013c, 5'h1e, 3);
    `CHK("status partial", 8'h3e, o_status)
    read_pad(16'h013c, 8'h3e);
    copy_pad(16'h013c, 8'h3e, full_pw);
    `CHK("status no copy", 8'h3e, o_status)
    $display("test partial done");
    // Register page is protected while the mission runs
    write_pad(16'h0900, 5'h1f, 0);
    copy_pad(16'h0900, 8'h1f, full_pw);
    `CHK("status protected", 8'h1f, o_status)
    $display("test protect done");
    // Wrong password: no copy, ones on the link
    mission <= 1'b0;
    write_pad(16'h0120, 5'h1f, 0);
    copy_pad(16'h0120, 8'h1f, ~full_pw);
    `CHK("status bad pw", 8'h1f, o_status)
    rd_byte(IDLE_FILL);
    $display("test password done");
    repeat (4) @(posedge i_core_clk);
    `CHK("notes left", 0, exp_q.size() + mem_q.size())
    stop_test();
  end
endmodule
`default_nettype wire
